// File: bench/ccpo_load_model.sv
`timescale 1ns/1ps
// ==========================================================
// external power stage: reads the pins, raises a fault line
module ccpo_load_model (
  input  wire logic       aclk,
  input  wire logic [5:0] oc_out,
  input  wire logic [5:0] oc_oe,
  input  wire logic       fault_req,
  output logic            shutdown_in,
  output logic [5:0]      pin_level
);
  logic [5:0] float_pat;

  initial begin
    float_pat   = 6'h15;
    shutdown_in = 1'h0;
  end

  // undriven pins float, so they show a changing pattern
  always @(posedge aclk) begin
    float_pat   <= ~float_pat;
    shutdown_in <= fault_req;
  end

  assign pin_level = (oc_out & oc_oe) | (float_pat & ~oc_oe);
endmodule : ccpo_load_model

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top import ccpo_pkg::*;;
  // ==========================================================
  // signals
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, shutdown_in;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [4:0]  ccp_sync = 5'h00;
  logic [3:0]  aux_sync = 4'h0;
  logic [3:0]  aux_mode = 4'h0;
  logic        trigger = 1'h0;
  logic        fault_req = 1'h0;
  logic [5:0]  oc_out, oc_oe, pin_level;
  logic [5:0]  oc_oe_s;
  logic [31:0] rdata_s, rd_s;
  int          fail_count = 0;
  int          samples_checked = 0;

  ccpo_top #(.MULTI_OUTPUT(1), .TB_DIV(1)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ccp_sync_in(ccp_sync), .aux_sync_in(aux_sync), .aux_sync_mode(aux_mode),
    .trigger_in(trigger), .shutdown_in(shutdown_in), .oc_out(oc_out), .oc_oe(oc_oe)
  );

  // single-output variant on the same bus, mirrors the handshakes of u_dut
  ccpo_top #(.MULTI_OUTPUT(0), .TB_DIV(1)) u_single (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
    .s_axi_rdata(rdata_s), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready),
    .ccp_sync_in(ccp_sync), .aux_sync_in(aux_sync), .aux_sync_mode(aux_mode),
    .trigger_in(trigger), .shutdown_in(shutdown_in), .oc_out(), .oc_oe(oc_oe_s)
  );

  ccpo_load_model u_load (
    .aclk(aclk), .oc_out(oc_out), .oc_oe(oc_oe), .fault_req(fault_req),
    .shutdown_in(shutdown_in), .pin_level(pin_level)
  );

  initial begin
    forever #4 aclk = ~aclk;
  end

  // ==========================================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    r = 2'h3;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'h0;
        break;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    r = 2'h3;
    d = 32'hDEAD_BEEF;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready) begin
        d = rdata;
        rd_s = rdata_s;
        r = rresp;
        rready <= 1'h0;
        break;
      end
    end
  endtask : axi_rd

  // ==========================================================
  // scenarios
  task automatic t_regs;
    axi_rd(ADDR_CTRL_HIGH, rd, resp); chk(rd, {16'h0000, CTRL_RESET});
    axi_rd(ADDR_SYNC_CFG, rd, resp); chk(rd, {23'h0, SYNC_RESET});
    axi_rd(ADDR_PERIOD, rd, resp); chk(rd, {16'h0000, PERIOD_RESET});
    axi_rd(ADDR_DUTY, rd, resp); chk(rd, {16'h0000, DUTY_RESET});
    axi_wr(ADDR_CTRL_HIGH, 32'hFFFF_FFFF, resp);
    axi_rd(ADDR_CTRL_HIGH, rd, resp); chk(rd, {16'h0000, MASK_MULTI});
    chk(rd_s, {16'h0000, MASK_SINGLE});
    axi_wr(ADDR_CTRL_HIGH, 32'h0000_0000, resp);
    axi_wr(ADDR_STATUS, 32'h0000_0000, resp); chk({30'h0, resp}, {30'h0, RESP_OKAY});
    axi_wr(8'h20, 32'h0000_1234, resp); chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_rd(8'h20, rd, resp); chk({rd[29:0], resp}, {30'h0, RESP_SLVERR});
    $display("test regs done");
  endtask : t_regs

  task automatic sync_case(input logic [4:0] code, input logic [3:0] mode,
                           input logic [4:0] cp, input logic [3:0] ax, input logic exp);
    axi_wr(ADDR_SYNC_CFG, {27'h0, code}, resp);
    aux_mode <= mode;
    tick(40);
    ccp_sync <= cp;
    aux_sync <= ax;
    @(posedge aclk);
    ccp_sync <= 5'h00;
    aux_sync <= 4'h0;
    axi_rd(ADDR_STATUS, rd, resp);
    chk({31'h0, rd[15:0] < 16'h0010}, {31'h0, exp});
  endtask : sync_case

  task automatic t_sync;
    sync_case(SYNC_NONE, 4'h0, 5'h1F, 4'hF, 1'h0);
    for (int i = 0; i < 5; i++) sync_case(SYNC_CCP_FIRST + 5'(i), 4'h0, 5'(1 << i), 4'h0, 1'h1);
    sync_case(SYNC_CCP_FIRST, 4'h0, 5'h1E, 4'h0, 1'h0);
    sync_case(5'h06, 4'hF, 5'h1F, 4'hF, 1'h0);
    sync_case(SYNC_TIMER, 4'h0, 5'h00, 4'h1, 1'h0);
    sync_case(SYNC_TIMER, 4'h1, 5'h00, 4'h1, 1'h1);
    sync_case(SYNC_LC_ONE, 4'h0, 5'h00, 4'h2, 1'h0);
    sync_case(SYNC_LC_ONE, 4'h2, 5'h00, 4'h2, 1'h1);
    sync_case(SYNC_LC_TWO, 4'h4, 5'h00, 4'h4, 1'h1);
    sync_case(SYNC_CONV, 4'h8, 5'h00, 4'h8, 1'h1);
    sync_case(SYNC_FREE, 4'hF, 5'h1F, 4'hF, 1'h0);
    $display("test sync done");
  endtask : t_sync

  task automatic t_roll;
    axi_wr(ADDR_PERIOD, 32'h0000_0009, resp);
    // bring the counter below the new period, else it runs on to FFFFh
    sync_case(SYNC_CCP_FIRST, 4'h0, 5'h01, 4'h0, 1'h1);
    axi_wr(ADDR_SYNC_CFG, 32'h0000_0000, resp);
    tick(30);
    axi_rd(ADDR_STATUS, rd, resp); chk({31'h0, rd[15:0] <= 16'h0009}, 32'h0000_0001);
    axi_wr(ADDR_SYNC_CFG, {27'h0, SYNC_FREE}, resp);
    tick(30);
    axi_rd(ADDR_STATUS, rd, resp); chk({31'h0, rd[15:0] > 16'h0009}, 32'h0000_0001);
    $display("test rollover done");
  endtask : t_roll

  task automatic t_pins;
    logic [5:0] en_tab [8];
    logic [1:0] c;
    en_tab = '{6'h01, 6'h03, 6'h03, 6'h00, 6'h0F, 6'h0F, 6'h00, 6'h00};
    axi_wr(ADDR_SYNC_CFG, 32'h0000_0000, resp);
    for (int m = 0; m < 8; m++) begin
      axi_wr(ADDR_CTRL_HIGH, 32'(m) << F_OUTM_LO, resp);
      tick(4);
      chk({26'h0, oc_oe}, {26'h0, en_tab[m]});
      chk({26'h0, oc_oe_s}, 32'h0000_0001);
      if (m == 5) chk({31'h0, pin_level[0]}, 32'h0000_0001);
      if (m == 4) chk({31'h0, pin_level[2]}, 32'h0000_0001);
    end
    for (int p = 0; p < 4; p++) begin
      axi_wr(ADDR_CTRL_HIGH, (32'(OUTM_HALF) << F_OUTM_LO) | (32'(p) << F_POL_TWO), resp);
      tick(4);
      chk({30'h0, pin_level[1:0]}, {30'h0, ~p[0], p[1]});
    end
    for (int k = 0; k < 4; k++) begin
      c = 2'(k);
      axi_wr(ADDR_CTRL_HIGH, 32'h0000_0220 | (32'(c) << F_PSS_ONE_LO) | 32'(c), resp);
      fault_req <= 1'h1;
      tick(5);
      chk({28'h0, oc_oe[1:0], pin_level[1:0] & oc_oe[1:0]},
          {28'h0, c[1], c[1], c[1] & c[0], c[1] & ~c[0]});
      fault_req <= 1'h0;
    end
    $display("test pins done");
  endtask : t_pins

  task automatic t_trig;
    axi_wr(ADDR_CTRL_HIGH, 32'h0000_B000, resp);
    axi_wr(ADDR_SYNC_CFG, 32'h0000_0101, resp);
    // restart the time base so rollovers follow the period
    ccp_sync <= 5'h01;
    @(posedge aclk);
    ccp_sync <= 5'h00;
    tick(19);
    chk({26'h0, oc_oe}, 32'h0000_0000);
    trigger <= 1'h1;
    @(posedge aclk);
    trigger <= 1'h0;
    tick(3);
    chk({31'h0, oc_oe[0]}, 32'h0000_0001);
    tick(17);
    axi_rd(ADDR_STATUS, rd, resp); chk({30'h0, rd[17:16]}, 32'h0000_0003);
    tick(30);
    axi_rd(ADDR_STATUS, rd, resp); chk({31'h0, rd[17]}, 32'h0000_0000);
    $display("test trigger done");
  endtask : t_trig

  // ==========================================================
  // run control
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_sync();
    t_roll();
    t_pins();
    t_trig();
    complete_run();
  end

  initial begin
    repeat (6000) @(posedge aclk);
    fail_count++;
    complete_run();
  end
endmodule : tb_top

// File: rtl/ccpo_pin_stage.sv
`timescale 1ns/1ps
module ccpo_pin_stage (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       active,
  input  wire logic       drive_en,
  input  wire logic       polarity,
  input  wire logic       shutdown,
  input  wire logic [1:0] shut_code,
  output logic            pin_out,
  output logic            pin_oe
);
  // ==========================================================================
  // registered pin driver
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else if (shutdown) begin
      pin_out <= shut_code[0] ^ polarity;
      pin_oe  <= shut_code[1];
    end else begin
      pin_out <= active ^ polarity;
      pin_oe  <= drive_en;
    end
  end
endmodule : ccpo_pin_stage

// File: rtl/ccpo_pkg.sv
package ccpo_pkg;
  // ==========================================================================
  // register byte offsets
  localparam logic [7:0]  ADDR_CTRL_HIGH = 8'h00;
  localparam logic [7:0]  ADDR_SYNC_CFG  = 8'h04;
  localparam logic [7:0]  ADDR_PERIOD    = 8'h08;
  localparam logic [7:0]  ADDR_DUTY      = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS    = 8'h10;
  // ==========================================================================
  // output control high fields
  localparam int          F_HOLDOFF      = 15;
  localparam int          F_OSCNT_LO     = 12;
  localparam int          F_OUTM_LO      = 8;
  localparam int          F_POL_ONE      = 5;
  localparam int          F_POL_TWO      = 4;
  localparam int          F_PSS_ONE_LO   = 2;
  localparam int          F_PSS_TWO_LO   = 0;
  localparam logic [15:0] MASK_MULTI     = 16'hF73F;
  localparam logic [15:0] MASK_SINGLE    = 16'hF02C;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  // ==========================================================================
  // sync configuration fields, period and duty resets, time base maximum
  localparam int          F_TRIG_EN      = 8;
  localparam logic [8:0]  MASK_SYNC      = 9'h11F;
  localparam logic [8:0]  SYNC_RESET     = 9'h000;
  localparam logic [15:0] PERIOD_RESET   = 16'hFFFF;
  localparam logic [15:0] DUTY_RESET     = 16'h0000;
  localparam logic [15:0] TB_MAX         = 16'hFFFF;
  // ==========================================================================
  // sync source codes
  localparam logic [4:0]  SYNC_NONE      = 5'h00;
  localparam logic [4:0]  SYNC_CCP_FIRST = 5'h01;
  localparam logic [4:0]  SYNC_CCP_LAST  = 5'h05;
  localparam logic [4:0]  SYNC_TIMER     = 5'h0B;
  localparam logic [4:0]  SYNC_LC_ONE    = 5'h11;
  localparam logic [4:0]  SYNC_LC_TWO    = 5'h12;
  localparam logic [4:0]  SYNC_CONV      = 5'h1B;
  localparam logic [4:0]  SYNC_FREE      = 5'h1F;
  // ==========================================================================
  // output modes and AXI response codes
  localparam logic [2:0]  OUTM_SINGLE    = 3'h0;
  localparam logic [2:0]  OUTM_PUSHPULL  = 3'h1;
  localparam logic [2:0]  OUTM_HALF      = 3'h2;
  localparam logic [2:0]  OUTM_BRUSH_REV = 3'h4;
  localparam logic [2:0]  OUTM_BRUSH_FWD = 3'h5;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage : ccpo_pkg

// File: rtl/ccpo_top.sv
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Summary of operation
// - Sync code 00000 runs the time base unsynchronised, rolling over at period match or FFFFh.
// - Sync codes 00001 to 00101 reset the time base from sibling capture/compare units one to five.
// - Codes 01011, 10001, 10010 and 11011 pick timer, logic cells and converter, if synchronous.
// - Sync code 11111 gives a free-running time base wrapping from FFFFh to 0000h.
// - With hold-off and triggered operation set, enabled pins stay undriven until a trigger, except during a shutdown with shutdown code 1x.
// - The one-shot count lengthens a one-shot event to N plus one time base periods.
// - Output modes 000, 001 and 010 select single (pin A only), push-pull and half-bridge.
// - Mode 101 is brush forward, 100 brush reverse; 011 and 111 are reserved.
// - Output mode and B/D/F polarity and shutdown controls exist only in the multi-output unit.
module ccpo_top import ccpo_pkg::*; #(
  parameter int          MULTI_OUTPUT = 1,
  parameter int          TB_DIV       = 1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [4:0]  ccp_sync_in,
  input  wire logic [3:0]  aux_sync_in,
  input  wire logic [3:0]  aux_sync_mode,
  input  wire logic        trigger_in,
  input  wire logic        shutdown_in,
  output logic [5:0]       oc_out,
  output logic [5:0]       oc_oe
);
  localparam logic [15:0] WMASK = (MULTI_OUTPUT != 0) ? MASK_MULTI : MASK_SINGLE;
  localparam int          DW    = (TB_DIV > 1) ? $clog2(TB_DIV) : 1;

  logic [15:0] ctrl_reg;
  logic [8:0]  sync_reg;
  logic [15:0] period_reg;
  logic [15:0] duty_reg;
  logic [15:0] cnt_reg;
  logic [DW-1:0] div_reg;
  logic        tick;
  logic        sync_hit;
  logic        period_end;
  logic        phase_reg;
  logic        run_reg;
  logic [2:0]  run_left_reg;
  logic        fired_reg;
  logic        trig_take;
  logic        run;
  logic        pwm;
  logic [5:0]  pin_active;
  logic [5:0]  pin_en;
  logic        aw_got_reg;
  logic        w_got_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic [31:0] rd_mux;
  logic        rd_hit;

  wire [4:0] sync_sel = sync_reg[4:0];
  wire       trig_en  = sync_reg[F_TRIG_EN];
  wire       holdoff  = ctrl_reg[F_HOLDOFF];
  wire [2:0] oscnt    = ctrl_reg[F_OSCNT_LO +: 3];
  wire [2:0] outm     = ctrl_reg[F_OUTM_LO +: 3];
  wire [15:0] bmask   = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}} & WMASK;
  wire [8:0]  smask   = {w_strb_reg[1], {8{w_strb_reg[0]}}};
  wire        do_wr   = aw_got_reg && w_got_reg && !s_axi_bvalid;

  // ==========================================================================
  // AXI4-Lite write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg    <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg    <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg == ADDR_CTRL_HIGH || aw_addr_reg == ADDR_SYNC_CFG ||
                         aw_addr_reg == ADDR_PERIOD || aw_addr_reg == ADDR_DUTY ||
                         aw_addr_reg == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // register file
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg   <= CTRL_RESET;
      sync_reg   <= SYNC_RESET;
      period_reg <= PERIOD_RESET;
      duty_reg   <= DUTY_RESET;
    end else if (do_wr) begin
      case (aw_addr_reg)
        ADDR_CTRL_HIGH: ctrl_reg <= (ctrl_reg & ~bmask) | (w_data_reg[15:0] & bmask);
        ADDR_SYNC_CFG:  sync_reg <= ((sync_reg & ~smask) | (w_data_reg[8:0] & smask))
                                    & MASK_SYNC;
        ADDR_PERIOD:    period_reg <= (period_reg & ~{{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}})
                                      | (w_data_reg[15:0] & {{8{w_strb_reg[1]}},
                                                              {8{w_strb_reg[0]}}});
        ADDR_DUTY:      duty_reg <= (duty_reg & ~{{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}})
                                    | (w_data_reg[15:0] & {{8{w_strb_reg[1]}},
                                                            {8{w_strb_reg[0]}}});
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      ADDR_CTRL_HIGH: rd_mux = {16'h0000, ctrl_reg};
      ADDR_SYNC_CFG:  rd_mux = {23'h00_0000, sync_reg};
      ADDR_PERIOD:    rd_mux = {16'h0000, period_reg};
      ADDR_DUTY:      rd_mux = {16'h0000, duty_reg};
      ADDR_STATUS:    rd_mux = {14'h0000, run, fired_reg, cnt_reg};
      default:        rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================================
  // time base tick divider
  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end
  assign tick = (TB_DIV <= 1) || (div_reg == DW'(TB_DIV - 1));

  // ==========================================================================
  // sync source select and time base
  always_comb begin
    case (sync_sel)
      5'h01, 5'h02, 5'h03, 5'h04, 5'h05:
        sync_hit = ccp_sync_in[3'(sync_sel - SYNC_CCP_FIRST)];
      SYNC_TIMER:  sync_hit = aux_sync_in[0] && aux_sync_mode[0];
      SYNC_LC_ONE: sync_hit = aux_sync_in[1] && aux_sync_mode[1];
      SYNC_LC_TWO: sync_hit = aux_sync_in[2] && aux_sync_mode[2];
      SYNC_CONV:   sync_hit = aux_sync_in[3] && aux_sync_mode[3];
      default:     sync_hit = 1'b0;
    endcase
  end

  assign period_end = tick && !sync_hit && (sync_sel == SYNC_FREE ? cnt_reg == TB_MAX :
                      (cnt_reg == period_reg || cnt_reg == TB_MAX));

  always_ff @(posedge aclk) begin
    if (!aresetn || sync_hit) begin
      cnt_reg <= 16'h0000;
    end else if (period_end) begin
      cnt_reg <= 16'h0000;
    end else if (tick) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // ==========================================================================
  // trigger, hold-off and one-shot length
  assign trig_take = trigger_in && trig_en && !run_reg;
  assign run       = !trig_en || run_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn || !trig_en) begin
      run_reg      <= 1'b0;
      run_left_reg <= 3'h0;
      fired_reg    <= 1'b0;
    end else if (trig_take) begin
      run_reg      <= 1'b1;
      run_left_reg <= oscnt;
      fired_reg    <= 1'b1;
    end else if (run_reg && period_end) begin
      if (run_left_reg == 3'h0) begin
        run_reg <= 1'b0;
      end else begin
        run_left_reg <= run_left_reg - 3'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_reg <= 1'b0;
    end else if (period_end) begin
      phase_reg <= !phase_reg;
    end
  end

  // ==========================================================================
  // output mode steering, pins ordered A B C D E F
  assign pwm = run && (cnt_reg < duty_reg);

  always_comb begin
    pin_active = 6'h00;
    pin_en     = 6'h00;
    case (MULTI_OUTPUT != 0 ? outm : OUTM_SINGLE)
      OUTM_SINGLE: begin
        pin_active[0] = pwm;
        pin_en        = 6'h01;
      end
      OUTM_PUSHPULL: begin
        pin_active[0] = pwm && !phase_reg;
        pin_active[1] = pwm && phase_reg;
        pin_en        = 6'h03;
      end
      OUTM_HALF: begin
        pin_active[0] = pwm;
        pin_active[1] = !pwm;
        pin_en        = 6'h03;
      end
      OUTM_BRUSH_FWD: begin
        pin_active[0] = run;
        pin_active[3] = pwm;
        pin_en        = 6'h0F;
      end
      OUTM_BRUSH_REV: begin
        pin_active[2] = run;
        pin_active[1] = pwm;
        pin_en        = 6'h0F;
      end
      default: pin_en = 6'h00;
    endcase
    if (trig_en && holdoff && !fired_reg) begin
      pin_en = 6'h00;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_pin
      localparam bit GROUP_ONE = (gi % 2) == 0;
      ccpo_pin_stage u_pin (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .active    (pin_active[gi]),
        .drive_en  (pin_en[gi]),
        .polarity  (GROUP_ONE ? ctrl_reg[F_POL_ONE] : ctrl_reg[F_POL_TWO]),
        .shutdown  (shutdown_in),
        .shut_code (GROUP_ONE ? ctrl_reg[F_PSS_ONE_LO +: 2] : ctrl_reg[F_PSS_TWO_LO +: 2]),
        .pin_out   (oc_out[gi]),
        .pin_oe    (oc_oe[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // assertions
  AST_NONE_ROLL: assert property (@(posedge aclk) disable iff (!aresetn)
    sync_sel == SYNC_NONE && tick && cnt_reg == period_reg |=> cnt_reg == 16'h0000)
    else $error("time base did not roll over at period match");
  AST_CCP_SYNC: assert property (@(posedge aclk) disable iff (!aresetn)
    sync_sel == 5'h03 && ccp_sync_in[2] |=> cnt_reg == 16'h0000)
    else $error("sibling sync pulse did not reset time base");
  AST_AUX_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    sync_sel == SYNC_LC_ONE && !aux_sync_mode[1] && tick && cnt_reg != period_reg
    && cnt_reg != TB_MAX |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("non-synchronous source reset the time base");
  AST_FREE_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
    sync_sel == SYNC_FREE && tick && cnt_reg == TB_MAX |=> cnt_reg == 16'h0000)
    else $error("free-running time base did not wrap");
  AST_HOLDOFF: assert property (@(posedge aclk) disable iff (!aresetn)
    trig_en && holdoff && !fired_reg && !shutdown_in |=> oc_oe == 6'h00)
    else $error("pins driven before trigger under hold-off");
  AST_ONESHOT: assert property (@(posedge aclk) disable iff (!aresetn)
    trig_take |=> run_reg && run_left_reg == $past(oscnt))
    else $error("one-shot length not loaded");
  AST_HALF: assert property (@(posedge aclk) disable iff (!aresetn)
    MULTI_OUTPUT != 0 && outm == OUTM_HALF && !shutdown_in
    && ctrl_reg[F_POL_ONE] == ctrl_reg[F_POL_TWO] && pin_en[0] |=> oc_out[0] != oc_out[1])
    else $error("half-bridge outputs not complementary");
  AST_RESERVED: assert property (@(posedge aclk) disable iff (!aresetn)
    (outm == 3'h3 || outm == 3'h7) && !shutdown_in |=> oc_oe == 6'h00)
    else $error("reserved output mode drove pins");
  AST_POLARITY: assert property (@(posedge aclk) disable iff (!aresetn)
    !shutdown_in |=> oc_out[0] == ($past(pin_active[0]) ^ $past(ctrl_reg[F_POL_ONE])))
    else $error("group one polarity wrong");
  AST_SHUT_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
    shutdown_in && ctrl_reg[F_PSS_ONE_LO +: 2] == 2'b11
    |=> oc_oe[0] && oc_out[0] == !$past(ctrl_reg[F_POL_ONE]))
    else $error("group one shutdown not active");
  AST_SHUT_TWO: assert property (@(posedge aclk) disable iff (!aresetn)
    shutdown_in && !ctrl_reg[F_PSS_TWO_LO + 1] |=> !oc_oe[1] && !oc_oe[3] && !oc_oe[5])
    else $error("group two not tri-stated in shutdown");
  AST_SINGLE: assert property (@(posedge aclk) disable iff (!aresetn)
    MULTI_OUTPUT == 0 |-> (ctrl_reg & ~MASK_SINGLE) == 16'h0000)
    else $error("multi-output controls present in single unit");
  AST_UNUSED: assert property (@(posedge aclk) disable iff (!aresetn)
    sync_sel == 5'h06 && tick && cnt_reg != period_reg && cnt_reg != TB_MAX
    |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("unused sync code affected time base");
  COV_SYNC: cover property (@(posedge aclk) disable iff (!aresetn) sync_hit ##1 tick);
  COV_ONESHOT: cover property (@(posedge aclk) disable iff (!aresetn)
    trig_take ##[1:200] (run_reg && period_end && run_left_reg == 3'h0));
  COV_SHUT: cover property (@(posedge aclk) disable iff (!aresetn) shutdown_in && pwm);
endmodule : ccpo_top
